// file: rtl/adc_consts.vh
// Constants for the converter control and result formatting block.
// Contract
// - Any control register write aborts a running conversion and never starts one.
// - Control bit 7 powers the converter; clearing it aborts any conversion.
// - Control bit 6 picks left (0) or right (1) justification in 10-bit mode.
// - In 8-bit mode justification only gates signing; result sits in the high byte.
// - Control bit 5 picks 10-bit (0) or 8-bit (1); 8-bit uses value bits 9-2.
// - Control bit 4 asks for signed output made by inverting the result MSB.
// - Signed output applies only with left justification; right justified is unsigned.
// - Signed range is 0x200 to 0x1FF at 10 bits, 0x80 to 0x7F at 8 bits.
// - Control bits 3:0 set the prescaler; divide factor is (setting + 1) * 2.
// - 10-bit right justified: full scale reads 0x03:0xFF, zero reads 0x00:0x00.
// - 10-bit left signed: full scale reads 0x7F:0xC0, zero reads 0x80:0x00.
// - 8-bit left unsigned: full scale reads 0xFF high, low byte always 0x00.
// - A status/control write clears the done flag, cancels interrupts, starts a conversion while control bit 7 is set.
// - Reading either result byte clears the done flag; each finish sets it.
// - Continuous mode repeats conversions; otherwise one conversion per status/control write made while powered.
// - Result bit positions unused by the selected format read as zero.
`ifndef ADC_CONSTS_VH
`define ADC_CONSTS_VH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define ADC_OFS_CONTROL    12'h000
`define ADC_OFS_STATUS_CTL 12'h004
`define ADC_OFS_RESULT_HI  12'h008
`define ADC_OFS_RESULT_LO  12'h00c
`define ADC_OFS_INT_STATUS 12'h010
`define ADC_OFS_INT_CLEAR  12'h014
`define ADC_OFS_INT_ENABLE 12'h018

// ****************************************************************
// Control register fields.
// ****************************************************************
`define ADC_CTL_POWER      7
`define ADC_CTL_JUSTIFY    6
`define ADC_CTL_EIGHT      5
`define ADC_CTL_SIGNED     4
`define ADC_CTL_PRS_HI     3
`define ADC_CTL_PRS_LO     0
`define ADC_CTL_RESET      8'h00

// ****************************************************************
// Status and control register fields.
// ****************************************************************
`define ADC_SC_DONE        7
`define ADC_SC_IE          6
`define ADC_SC_CONT        5
`define ADC_SC_CH_HI       4
`define ADC_SC_CH_LO       0
`define ADC_SC_RESET       8'h1f

// ****************************************************************
// Interrupt status bits and conversion timing.
// ****************************************************************
`define ADC_INT_DONE       0
`define ADC_INT_ABORT      1
`define ADC_INT_WIDTH      2
`define ADC_INT_RESET      2'h0
`define ADC_CONV_TICKS     5'h0e
`define ADC_TICK_RESET     5'h00
`define ADC_SIGN_10        10'h200
`define ADC_SIGN_8         8'h80

`endif

// file: rtl/adc_prescaler.v
// Conversion clock prescaler that divides the bus clock by (setting + 1) * 2.
`default_nettype none
`include "adc_consts.vh"

module adc_prescaler (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       run,
    input  wire [3:0] prescale_setting,
    output reg        conv_clk_ff,
    output reg        tick_ff
);

    reg  [3:0] count_ff;
    wire       wrap;

    // The half period ends after setting plus one bus cycles.
    assign wrap = (count_ff >= prescale_setting);

    // Count, toggle the conversion clock and pulse on its rising edge.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_ff    <= 4'h0;
            conv_clk_ff <= 1'b0;
            tick_ff     <= 1'b0;
        end else if (!run) begin
            count_ff    <= 4'h0;
            conv_clk_ff <= 1'b0;
            tick_ff     <= 1'b0;
        end else if (wrap) begin
            count_ff    <= 4'h0;
            conv_clk_ff <= ~conv_clk_ff;
            tick_ff     <= ~conv_clk_ff;
        end else begin
            count_ff    <= count_ff + 4'h1;
            tick_ff     <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: rtl/adc_formatter.v
// Maps a 10-bit conversion value onto the two result bytes.
`default_nettype none
`include "adc_consts.vh"

module adc_formatter (
    input  wire [9:0] raw_value,
    input  wire       eight_bit_select,
    input  wire       justify_select,
    input  wire       signed_select,
    output reg  [7:0] result_high,
    output reg  [7:0] result_low
);

    reg       use_sign;
    reg [9:0] val10;
    reg [7:0] val8;

    // Select the byte layout; unused bit positions are forced to zero.
    always @* begin
        use_sign = signed_select & ~justify_select;
        val10    = raw_value ^ (use_sign ? `ADC_SIGN_10 : 10'h000);
        val8     = raw_value[9:2] ^ (use_sign ? `ADC_SIGN_8 : 8'h00);
        if (eight_bit_select) begin
            result_high = val8;
            result_low  = 8'h00;
        end else if (justify_select) begin
            result_high = {6'h00, val10[9:8]};
            result_low  = val10[7:0];
        end else begin
            result_high = val10[9:2];
            result_low  = {val10[1:0], 6'h00};
        end
    end

endmodule
`default_nettype wire

// file: rtl/adc_control_result_format.v
// Converter control, result formatting and APB register slave.
`default_nettype none
`include "adc_consts.vh"

module adc_control_result_format (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [9:0]  sample_value,
    output reg         irq,
    output wire        conv_clk,
    output reg         busy,
    output reg         power_enable,
    output reg  [4:0]  channel_select
);

    // ************************************************************
    // Registers and wires.
    // ************************************************************
    // Software-visible state and result bytes.
    reg  [7:0]  adc_control_reg_ff;
    reg  [2:0]  sc_ctl_ff;
    reg         done_ff;
    reg  [7:0]  result_high_ff;
    reg  [7:0]  result_low_ff;
    reg  [1:0]  int_status_ff;
    reg  [1:0]  int_enable_ff;
    // Sequencer count and input stages.
    reg  [4:0]  ticks_ff;
    reg  [9:0]  sample_meta_ff;
    reg  [9:0]  sample_sync_ff;
    reg  [9:0]  sample_last_ff;
    reg  [9:0]  sample_hold_ff;
    // Next values of the clocked outputs.
    reg  [31:0] nxt_prdata;
    reg         nxt_pslverr;
    reg         nxt_busy;
    reg         nxt_done;
    reg  [1:0]  nxt_int_status;
    reg         nxt_irq;
    // Bus strobes and sequencer events.
    wire        setup;
    wire        access;
    wire        wr_ctl;
    wire        wr_sc;
    wire        wr_iclr;
    wire        wr_ien;
    wire        rd_result;
    wire        tick;
    wire        finish;
    wire        abort;
    wire        start;
    wire [7:0]  fmt_high;
    wire [7:0]  fmt_low;
    wire [1:0]  set_bits;

    // Reset image of the status register;
    // each field takes its own slice of it.
    localparam [7:0] sc_reset_bits = `ADC_SC_RESET;

    // ************************************************************
    // APB decode.
    // ************************************************************

    // Setup and access phases, and the strobes taken at the access edge.
    // Effects wait for the access edge, so a
    // transfer dropped after setup does nothing.
    // Addresses are compared in full: no alias
    // exists, and unused offsets answer with an
    // error instead.
    assign setup     = psel & ~penable;
    assign access    = psel & penable & pready;
    assign wr_ctl    = access & pwrite & (paddr == `ADC_OFS_CONTROL);
    assign wr_sc     = access & pwrite & (paddr == `ADC_OFS_STATUS_CTL);
    assign wr_iclr   = access & pwrite & (paddr == `ADC_OFS_INT_CLEAR);
    assign wr_ien    = access & pwrite & (paddr == `ADC_OFS_INT_ENABLE);
    assign rd_result = access & ~pwrite &
                       ((paddr == `ADC_OFS_RESULT_HI) | (paddr == `ADC_OFS_RESULT_LO));

    // Read data and error answer are prepared in the setup cycle.
    // The mux depends on the address only; its
    // value enters prdata at the setup edge.
    // Write-only and unmapped words read zero,
    // as do the upper 24 bits of each word.
    always @* begin
        nxt_prdata  = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        case (paddr)
            `ADC_OFS_CONTROL:    nxt_prdata = {24'h000000, adc_control_reg_ff};
            `ADC_OFS_STATUS_CTL: nxt_prdata = {24'h000000, done_ff, sc_ctl_ff[2:1], channel_select};
            `ADC_OFS_RESULT_HI:  nxt_prdata = {24'h000000, result_high_ff};
            `ADC_OFS_RESULT_LO:  nxt_prdata = {24'h000000, result_low_ff};
            `ADC_OFS_INT_STATUS: nxt_prdata = {30'h00000000, int_status_ff};
            `ADC_OFS_INT_CLEAR:  nxt_prdata = 32'h0000_0000;
            `ADC_OFS_INT_ENABLE: nxt_prdata = {30'h00000000, int_enable_ff};
            default:             nxt_pslverr = 1'b1;
        endcase
    end

    // Bus answer registers; pready is high from the first edge after reset.
    // With pready high, each access lasts one
    // cycle and no wait state is ever added.
    // prdata and pslverr stand until the next
    // setup, so the access edge sees them fixed.
    // An error answer has no effect on state.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata  <= pwrite ? 32'h0000_0000 : nxt_prdata;
                pslverr <= nxt_pslverr;
            end
        end
    end

    // ************************************************************
    // Control registers.
    // ************************************************************

    // Software-written control and status/control fields.
    // power_enable copies control bit 7; the
    // write that clears it aborts by itself.
    // sc_ctl_ff keeps the enable, continuous
    // and top channel bits of a status write;
    // channel_select takes the whole field.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            adc_control_reg_ff <= `ADC_CTL_RESET;
            sc_ctl_ff          <= sc_reset_bits[`ADC_SC_IE:`ADC_SC_CH_HI];
            channel_select     <= sc_reset_bits[`ADC_SC_CH_HI:`ADC_SC_CH_LO];
            int_enable_ff      <= `ADC_INT_RESET;
            power_enable       <= 1'b0;
        end else begin
            if (wr_ctl) begin
                adc_control_reg_ff <= pwdata[7:0];
                power_enable       <= pwdata[`ADC_CTL_POWER];
            end
            if (wr_sc) begin
                sc_ctl_ff      <= {pwdata[`ADC_SC_IE], pwdata[`ADC_SC_CONT], pwdata[`ADC_SC_CH_HI]};
                channel_select <= pwdata[`ADC_SC_CH_HI:`ADC_SC_CH_LO];
            end
            if (wr_ien)
                int_enable_ff <= pwdata[`ADC_INT_WIDTH-1:0];
        end
    end

    // ************************************************************
    // Conversion sequencing.
    // ************************************************************

    // A conversion runs for a fixed number of
    // conversion clock ticks; the input word is
    // taken at its finish edge.
    // The analog value comes from outside the clock domain.
    // Bits of one word may settle in different
    // cycles, so a word reaches the hold stage
    // only once it has stayed the same for two
    // cycles; a result never mixes two inputs.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sample_meta_ff <= 10'h000;
            sample_sync_ff <= 10'h000;
            sample_last_ff <= 10'h000;
            sample_hold_ff <= 10'h000;
        end else begin
            sample_meta_ff <= sample_value;
            sample_sync_ff <= sample_meta_ff;
            sample_last_ff <= sample_sync_ff;
            if (sample_sync_ff == sample_last_ff)
                sample_hold_ff <= sample_sync_ff;
        end
    end

    // The prescaler runs only while busy; a
    // stop clears its count, so each conversion
    // begun from idle starts with a full conversion clock half
    // period.
    adc_prescaler u_prescaler (
        .ref_clk          (ref_clk),
        .rst              (rst),
        .run              (busy),
        .prescale_setting (adc_control_reg_ff[`ADC_CTL_PRS_HI:`ADC_CTL_PRS_LO]),
        .conv_clk_ff      (conv_clk),
        .tick_ff          (tick)
    );

    // The formatter follows the control byte;
    // the layout standing at the finish edge is
    // the one captured.
    adc_formatter u_formatter (
        .raw_value        (sample_hold_ff),
        .eight_bit_select (adc_control_reg_ff[`ADC_CTL_EIGHT]),
        .justify_select   (adc_control_reg_ff[`ADC_CTL_JUSTIFY]),
        .signed_select    (adc_control_reg_ff[`ADC_CTL_SIGNED]),
        .result_high      (fmt_high),
        .result_low       (fmt_low)
    );

    // Abort, start and finish conditions; a control write never starts.
    // A status write while busy restarts from
    // tick zero. A control write in the same
    // edge wins, and nothing starts. A finish
    // needs the last tick with no abort and no
    // restart in that edge.
    assign abort  = busy & (wr_ctl | ~power_enable);
    assign start  = wr_sc & power_enable & ~wr_ctl;
    assign finish = busy & ~abort & ~wr_sc & tick & (ticks_ff == `ADC_CONV_TICKS);

    // Next busy state; continuous mode restarts on each finish.
    // Abort wins over start, start over a
    // finish. In single mode the finish drops
    // busy; in continuous mode it keeps it
    // high.
    always @* begin
        nxt_busy = busy;
        if (abort)
            nxt_busy = 1'b0;
        else if (start)
            nxt_busy = 1'b1;
        else if (finish)
            nxt_busy = sc_ctl_ff[1];
    end

    // Busy flag, tick count and result capture.
    // The tick count restarts on abort, start
    // and finish. Results change only at a
    // finish, so an abort keeps the old bytes
    // readable.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy           <= 1'b0;
            ticks_ff       <= `ADC_TICK_RESET;
            result_high_ff <= 8'h00;
            result_low_ff  <= 8'h00;
        end else begin
            busy <= nxt_busy;
            if (abort | start | finish)
                ticks_ff <= `ADC_TICK_RESET;
            else if (busy & tick)
                ticks_ff <= ticks_ff + 5'h01;
            if (finish) begin
                result_high_ff <= fmt_high;
                result_low_ff  <= fmt_low;
            end
        end
    end

    // ************************************************************
    // Done flag and interrupts.
    // ************************************************************

    // Status bit 0 records a finish, bit 1 an
    // abort; the enable register has the same
    // layout.
    assign set_bits = {abort, finish};

    // Flag and sticky bits; a set in the clearing cycle wins.
    // A clear and a set in one edge keep the
    // bit set, so no finish is lost. A status
    // write cancels every pending interrupt,
    // the abort bit too. irq follows the next
    // state, in the same edge as its sources.
    always @* begin
        nxt_done = done_ff;
        if (wr_sc | rd_result)
            nxt_done = 1'b0;
        if (finish)
            nxt_done = 1'b1;
        nxt_int_status = int_status_ff;
        if (wr_iclr)
            nxt_int_status = nxt_int_status & ~pwdata[`ADC_INT_WIDTH-1:0];
        if (wr_sc)
            nxt_int_status = `ADC_INT_RESET;
        nxt_int_status = nxt_int_status | set_bits;
        nxt_irq = |(nxt_int_status & int_enable_ff) | (nxt_done & sc_ctl_ff[2]);
    end

    // Flag, status and interrupt output registers.
    // irq is a flop, so it never glitches
    // while the bus clears a bit behind it.
    // Reset leaves every interrupt cancelled.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done_ff       <= 1'b0;
            int_status_ff <= `ADC_INT_RESET;
            irq           <= 1'b0;
        end else begin
            done_ff       <= nxt_done;
            int_status_ff <= nxt_int_status;
            irq           <= nxt_irq;
        end
    end

endmodule
`default_nettype wire

// file: test/adc_crf_chk.sv
// Port-level assertion checker for the converter control block.
`default_nettype none
`include "adc_consts.vh"
module adc_crf_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [9:0]  sample_value,
    input wire logic        irq,
    input wire logic        conv_clk,
    input wire logic        busy,
    input wire logic        power_enable,
    input wire logic [4:0]  channel_select
);
    // ****************************************************************
    // Bus decode and helper state.
    // ****************************************************************
    wire logic       acc    = psel && penable && pready;
    wire logic       wr_ctl = acc && pwrite && paddr == `ADC_OFS_CONTROL;
    wire logic       wr_sc  = acc && pwrite && paddr == `ADC_OFS_STATUS_CTL;
    logic      [3:0] prs_ff;
    logic            cont_ff;
    logic            sc_wr_ff;
    logic      [4:0] hi_cnt_ff;
    // Keeps the prescale and mode settings and counts the high phase of the divided clock.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prs_ff <= 4'h0;
            cont_ff <= 1'h0;
            sc_wr_ff <= 1'h0;
            hi_cnt_ff <= 5'h00;
        end else begin
            prs_ff <= wr_ctl ? pwdata[3:0] : prs_ff;
            cont_ff <= wr_sc ? pwdata[`ADC_SC_CONT] : cont_ff;
            sc_wr_ff <= wr_sc;
            hi_cnt_ff <= conv_clk ? hi_cnt_ff + 5'h01 : 5'h00;
        end
    end
    // ****************************************************************
    // Assertions and covers.
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_ctl_abort: assert property (wr_ctl |=> !busy [*2])
        else $error("control write left the converter busy");
    a_power_copy: assert property (wr_ctl |=> power_enable == $past(pwdata[`ADC_CTL_POWER]))
        else $error("power enable does not follow control bit 7");
    a_off_idle: assert property (!power_enable |=> !busy)
        else $error("converter busy while powered down");
    a_sc_start: assert property (wr_sc && power_enable |=> busy)
        else $error("status write did not start a conversion");
    a_clk_idle: assert property (!busy && !$past(busy) |-> !conv_clk)
        else $error("conversion clock runs while idle");
    a_clk_half: assert property ($fell(conv_clk) && busy && !sc_wr_ff |-> hi_cnt_ff == prs_ff + 5'h01)
        else $error("conversion clock high phase has wrong length");
    a_one_shot: assert property ($rose(busy) && !cont_ff |-> ##[1:600] !busy)
        else $error("single conversion did not end");
    a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    c_abort: cover property (wr_ctl && busy);
    c_finish: cover property ($fell(busy));
    c_irq: cover property ($rose(irq));
endmodule

bind adc_control_result_format adc_crf_chk u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_value(sample_value), .irq(irq), .conv_clk(conv_clk), .busy(busy), .power_enable(power_enable),
    .channel_select(channel_select));
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the converter control block.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals, design instance and clock.
    // ****************************************************************
    logic        ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, seed = 32'hd2662912;
    logic [9:0]  sample_value = 10'h000;
    wire logic [31:0] prdata;
    wire logic        pready, pslverr, irq, conv_clk, busy, power_enable;
    wire logic [4:0]  channel_select;
    int          fails = 0, checked = 0;
    logic [32:0] notes[$];
    adc_control_result_format u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_value(sample_value), .irq(irq), .conv_clk(conv_clk), .busy(busy), .power_enable(power_enable),
        .channel_select(channel_select));
    // Free-running 200 MHz clock.
    always #2.5 ref_clk = ~ref_clk;
    // ****************************************************************
    // Helpers.
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic finish_test();
        $display("Counts: %0d compared, %0d mismatched", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [32:0] e);
        checked++;
        if ({pslverr, prdata} !== e) begin
            fails++;
            $display("Error at %0t: read gave %h, expected %h", $time, {pslverr, prdata}, e);
        end
    endtask
    task automatic fl(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: status output is %b, expected %b", $time, got, exp);
        end
    endtask
    // One bus transfer; it returns at the falling edge so outputs have settled.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        psel <= 1'h0;
        penable <= 1'h0;
        @(negedge ref_clk);
        if (n >= 50) begin
            fails++;
            $display("Error at %0t: no ready", $time);
            finish_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'h1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic e);
        notes.push_back({e, 24'h0, d});
        xfer(1'h0, a, 8'h00);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (2) @(negedge ref_clk);
        while (busy !== 1'h0 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 2000) begin
            fails++;
            $display("Error at %0t: conversion never ended", $time);
            finish_test();
        end
    endtask
    // One conversion in format m = {eight_bit, justify, signed}, then the result bytes are read.
    task automatic fmt_case(input logic [2:0] m, input logic [9:0] v);
        logic [15:0] r;
        logic [7:0]  c;
        seed = xs(seed);
        c = {1'h1, m[1], m[2], m[0], seed[3:0]};
        r = m[2] ? {v[9] ^ (m[0] & !m[1]), v[8:2], 8'h00} : m[1] ? {6'h00, v} : {v[9] ^ m[0], v[8:0], 6'h00};
        @(posedge ref_clk);
        sample_value <= v;
        wr(12'h000, c);
        fl(power_enable, 1'h1);
        rd(12'h000, c, 1'h0);
        wr(12'h004, {3'h0, seed[8:4]});
        fl({3'h0, channel_select}, {3'h0, seed[8:4]});
        wait_idle();
        rd(12'h004, {3'h4, seed[8:4]}, 1'h0);
        rd(12'h008, r[15:8], 1'h0);
        rd(12'h00c, r[7:0], 1'h0);
        rd(12'h004, {3'h0, seed[8:4]}, 1'h0);
    endtask
    // Compares each read against the oldest note.
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite && notes.size() > 0) begin
            cmp(notes.pop_front());
        end
    end
    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        $display("Error at %0t: run limit reached", $time);
        finish_test();
    end
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'h0;
        rd(12'h000, 8'h00, 1'h0);
        rd(12'h004, 8'h1f, 1'h0);
        rd(12'h018, 8'h00, 1'h0);
        rd(12'h01c, 8'h00, 1'h1);
        fl({3'h0, channel_select}, 8'h1f);
        $display("reset and map test done");
        for (int i = 0; i < 24; i++) begin
            fmt_case(i[2:0], i < 8 ? 10'h3ff : i < 16 ? 10'h000 : seed[9:0]);
        end
        $display("format test done");
        wr(12'h000, 8'h80);
        wr(12'h014, 8'h03);
        wr(12'h018, 8'h03);
        wr(12'h004, 8'h00);
        repeat (10) @(negedge ref_clk);
        wr(12'h000, 8'h80);
        fl(busy, 1'h0);
        rd(12'h010, 8'h02, 1'h0);
        rd(12'h004, 8'h00, 1'h0);
        fl(irq, 1'h1);
        wr(12'h014, 8'h02);
        repeat (2) @(negedge ref_clk);
        fl(irq, 1'h0);
        rd(12'h014, 8'h00, 1'h0);
        wr(12'h004, 8'h40);
        wait_idle();
        fl(irq, 1'h1);
        wr(12'h018, 8'h00);
        fl(irq, 1'h1);
        rd(12'h00c, {sample_value[1:0], 6'h00}, 1'h0);
        repeat (2) @(negedge ref_clk);
        fl(irq, 1'h0);
        wr(12'h008, 8'hff);
        rd(12'h008, sample_value[9:2], 1'h0);
        $display("abort and interrupt test done");
        wr(12'h000, 8'h00);
        wr(12'h004, 8'h00);
        repeat (3) @(negedge ref_clk);
        fl(busy, 1'h0);
        fl(power_enable, 1'h0);
        wr(12'h000, 8'h80);
        wr(12'h004, 8'h20);
        repeat (80) @(negedge ref_clk);
        fl(busy, 1'h1);
        rd(12'h004, 8'ha0, 1'h0);
        wr(12'h000, 8'h80);
        fl(busy, 1'h0);
        $display("power and continuous test done");
        finish_test();
    end
endmodule
`default_nettype wire
